// ---- design/piosi_bus_if.sv ----
// the programmed-io bus lines joining the bus controller and one device controller
`timescale 1ns/1ps
interface piosi_bus_if;
    logic [5:0] selCode;
    logic selValid;
    logic busyStatusLine;
    logic doneStatusLine;
    logic startPulse;
    logic clearPulse;
    logic generalPulse;
    logic ioResetPulse;
    logic requestEnableStrobe;
    logic irqRequestLine;
    logic irqAcknowledge;
    logic irqPriorityInput;
    logic irqPriorityOutput;
    logic [15:0] ackData;
    logic ackDataEn;
    logic channelRequestLine;

    // device end
    modport device (
        input selCode, selValid, startPulse, clearPulse, generalPulse, ioResetPulse,
        input requestEnableStrobe, irqAcknowledge, irqPriorityInput,
        output busyStatusLine, doneStatusLine, irqRequestLine, irqPriorityOutput,
        output ackData, ackDataEn, channelRequestLine
    );
    // bus controller end
    modport host (
        output selCode, selValid, startPulse, clearPulse, generalPulse, ioResetPulse,
        output requestEnableStrobe, irqAcknowledge, irqPriorityInput,
        input busyStatusLine, doneStatusLine, irqRequestLine, irqPriorityOutput,
        input ackData, ackDataEn, channelRequestLine
    );
endinterface

// ---- design/piosi_device.sv ----
// device-controller end: busy/done flags, status lines, irq and channel request, priority
`timescale 1ns/1ps
module piosi_device
    import piosi_pkg::*;
#(
    parameter logic [5:0] DEV_CODE = 6'h11  // arbitrary default device code
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // bus side
    piosi_bus_if.device bus,
    // device user side
    input wire logic operationFinishedSignal,
    input wire logic irqDisable,
    input wire logic channelWanted,
    output logic busyFlag,
    output logic doneFlag,
    output logic startSeen,
    output logic generalSeen
);
    // ------------------------------------------------------------
    // pin synchronisers: three flops, change taken when last two agree
    // ------------------------------------------------------------
    localparam int NSYNC = 11;
    logic [NSYNC-1:0] rawIn;
    logic [NSYNC-1:0] syncA_reg, syncB_reg, syncC_reg;
    logic [NSYNC-1:0] clean_reg;
    assign rawIn = {bus.selCode, bus.selValid, bus.startPulse, bus.clearPulse,
                    bus.ioResetPulse, bus.requestEnableStrobe};
    // strobe idles high, so its stages reset high to avoid a false falling edge
    localparam logic [10:0] SYNC_RST = 11'h001;

    // three-stage capture of the select, start, clear, reset and strobe lines
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            syncA_reg <= SYNC_RST;
            syncB_reg <= SYNC_RST;
            syncC_reg <= SYNC_RST;
        end else begin
            syncA_reg <= rawIn;
            syncB_reg <= syncA_reg;
            syncC_reg <= syncB_reg;
        end
    end

    // per bit filtered value: follows only when stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : gFilt
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    clean_reg[gi] <= SYNC_RST[gi];
                end else if (syncB_reg[gi] == syncC_reg[gi]) begin
                    clean_reg[gi] <= syncC_reg[gi];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // decoded levels and edges
    // ------------------------------------------------------------
    logic [5:0] selCodeS;
    logic selValidS, startS, clearS, ioRstS, strobeS;
    logic [NSYNC-1:0] cleanPrev_reg;
    assign {selCodeS, selValidS, startS, clearS, ioRstS, strobeS} = clean_reg;

    // previous filtered values for edge detection
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cleanPrev_reg <= SYNC_RST;
        end else begin
            cleanPrev_reg <= clean_reg;
        end
    end

    logic selected, startEdge, clearEdge, ioRstEdge, strobeFall, finishPrev_reg, finishEdge;
    assign selected = selValidS && (selCodeS == DEV_CODE);
    assign startEdge = startS && !cleanPrev_reg[3] && selected;
    assign clearEdge = clearS && !cleanPrev_reg[2] && selected;
    assign ioRstEdge = ioRstS && !cleanPrev_reg[1];
    assign strobeFall = !strobeS && cleanPrev_reg[0];

    // completion is from local logic on clk: no synchroniser needed
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            finishPrev_reg <= 1'b0;
        end else begin
            finishPrev_reg <= operationFinishedSignal;
        end
    end
    assign finishEdge = operationFinishedSignal && !finishPrev_reg;

    // ------------------------------------------------------------
    // busy/done network
    // ------------------------------------------------------------
    logic busy_reg, done_reg;
    // busy: reset wins, then clear, then start, then completion
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busy_reg <= 1'b0;
        end else if (ioRstEdge) begin
            busy_reg <= 1'b0;
        end else if (clearEdge) begin
            busy_reg <= 1'b0;
        end else if (startEdge) begin
            busy_reg <= 1'b1;
        end else if (finishEdge) begin
            busy_reg <= 1'b0;
        end
    end

    // done copies busy on completion, so a busy already cleared leaves done low
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            done_reg <= 1'b0;
        end else if (ioRstEdge) begin
            done_reg <= 1'b0;
        end else if (finishEdge && busy_reg) begin
            done_reg <= 1'b1;
        end else if (clearEdge || startEdge || finishEdge) begin
            done_reg <= 1'b0;
        end
    end

    // status lines only while our code is on the select lines
    assign bus.busyStatusLine = selected && busy_reg;
    assign bus.doneStatusLine = selected && done_reg;
    assign busyFlag = busy_reg;
    assign doneFlag = done_reg;

    // one-cycle notifications of start and general pulses to the device logic
    logic genEdge, genPrev_reg, startSeen_reg, generalSeen_reg;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            genPrev_reg <= 1'b0;
            startSeen_reg <= 1'b0;
            generalSeen_reg <= 1'b0;
        end else begin
            genPrev_reg <= bus.generalPulse;
            startSeen_reg <= startEdge;
            generalSeen_reg <= genEdge;
        end
    end
    // general pulse sampled raw in one flop: it only makes a notification
    assign genEdge = bus.generalPulse && !genPrev_reg && selected;
    assign startSeen = startSeen_reg;
    assign generalSeen = generalSeen_reg;

    // ------------------------------------------------------------
    // request flops: change only on strobe falling edge
    // ------------------------------------------------------------
    logic irq_reg, dchReq_reg;
    // acknowledge leaves busy/done untouched; servicing comes from software
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_reg <= 1'b0;
        end else if (strobeFall) begin
            irq_reg <= done_reg && !irqDisable;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dchReq_reg <= 1'b0;
        end else if (strobeFall) begin
            dchReq_reg <= channelWanted;
        end
    end
    assign bus.irqRequestLine = irq_reg;
    assign bus.channelRequestLine = dchReq_reg;

    // ------------------------------------------------------------
    // priority element and acknowledge answer
    // ------------------------------------------------------------
    // combinational pass-through keeps the chain fast across chained elements
    assign bus.irqPriorityOutput = bus.irqPriorityInput && !irq_reg;
    assign bus.ackDataEn = bus.irqAcknowledge && bus.irqPriorityInput && irq_reg;
    assign bus.ackData = bus.ackDataEn ? {{(DATA_W - DEV_CODE_W){1'b0}}, DEV_CODE}
                                       : '0;
endmodule

// ---- design/piosi_host.sv ----
// bus controller end: apb command registers sequencing skip, flag, acknowledge and reset
`timescale 1ns/1ps
module piosi_host
    import piosi_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // bus side
    piosi_bus_if.host bus,
    // priority chain head
    input wire logic chainHeadAsserted
);
    // ------------------------------------------------------------
    // command registers and sequencer
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1, ST_XFER = 4'h2, ST_PULSE = 4'h4, ST_END = 4'h8
    } piosi_state_e;
    piosi_state_e state_reg;
    logic [3:0] cnt_reg;
    logic [5:0] dev_reg;
    logic [1:0] op_reg, test_reg, flag_reg;
    logic irqOn_reg, skip_reg, strobe_reg;
    logic [15:0] result_reg;
    logic wr, go, last;
    assign wr = psel && penable && pwrite;
    assign go = wr && (paddr == REG_CMD) && (state_reg == ST_IDLE);
    assign last = (cnt_reg == PHASE_CYCLES);

    // accepts one command while idle; commands written while busy are dropped
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dev_reg <= '0;
            op_reg <= OP_SKIP;
            test_reg <= SKIP_IF_BUSY_ASSERTED;
            flag_reg <= FLAG_NONE;
            irqOn_reg <= 1'b0;
        end else if (go) begin
            dev_reg <= pwdata[CMD_DEV_LSB +: DEV_CODE_W];
            op_reg <= pwdata[CMD_OP_LSB +: 2];
            test_reg <= pwdata[CMD_TEST_LSB +: SKIP_TEST_W];
            flag_reg <= pwdata[CMD_FLAG_LSB +: 2];
            irqOn_reg <= pwdata[CMD_IRQON_BIT];
        end
    end

    // phases: transfer, flag pulse, then request-enable strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
            cnt_reg <= '0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    cnt_reg <= '0;
                    if (go) begin
                        state_reg <= ST_XFER;
                    end
                end
                ST_XFER: begin
                    cnt_reg <= last ? 4'h0 : cnt_reg + 4'h1;
                    if (last) begin
                        state_reg <= ST_PULSE;
                    end
                end
                ST_PULSE: begin
                    cnt_reg <= last ? 4'h0 : cnt_reg + 4'h1;
                    if (last) begin
                        state_reg <= ST_END;
                    end
                end
                ST_END: begin
                    cnt_reg <= last ? 4'h0 : cnt_reg + 4'h1;
                    if (last) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // bus drive
    // ------------------------------------------------------------
    logic isAck;
    assign isAck = (op_reg == OP_ACK);
    assign bus.selCode = isAck ? ACK_DEV_CODE : dev_reg;
    assign bus.selValid = (state_reg != ST_IDLE);
    assign bus.irqAcknowledge = isAck && (state_reg == ST_XFER);
    // flag pulse only in the middle phase, after the transfer
    assign bus.startPulse = (state_reg == ST_PULSE) && (op_reg == OP_FLAG)
                            && (flag_reg == FLAG_START);
    assign bus.clearPulse = (state_reg == ST_PULSE) && (op_reg == OP_FLAG)
                            && (flag_reg == FLAG_CLEAR);
    assign bus.generalPulse = (state_reg == ST_PULSE) && (op_reg == OP_FLAG)
                              && (flag_reg == FLAG_PULSE);
    assign bus.ioResetPulse = (state_reg == ST_PULSE) && (op_reg == OP_RESET);
    assign bus.irqPriorityInput = chainHeadAsserted;

    // strobe low two cycles in ST_END so the device's filter sees it; never during acknowledge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            strobe_reg <= 1'b1;
        end else begin
            strobe_reg <= !((state_reg == ST_END) && !isAck && cnt_reg <= 4'h1);
        end
    end
    assign bus.requestEnableStrobe = strobe_reg;

    // skip test and acknowledge capture at end of transfer
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            skip_reg <= 1'b0;
            result_reg <= '0;
        end else if (state_reg == ST_XFER && last) begin
            case (test_reg)
                SKIP_IF_BUSY_ASSERTED: skip_reg <= bus.busyStatusLine;
                SKIP_IF_BUSY_CLEAR: skip_reg <= !bus.busyStatusLine;
                SKIP_IF_DONE_ASSERTED: skip_reg <= bus.doneStatusLine;
                SKIP_IF_DONE_CLEAR: skip_reg <= !bus.doneStatusLine;
                default: skip_reg <= 1'b0;
            endcase
            if (isAck) begin
                result_reg <= bus.ackDataEn ? bus.ackData : '0;
            end
        end
    end

    // ------------------------------------------------------------
    // apb read side: zero wait states
    // ------------------------------------------------------------
    logic irqTaken;
    assign irqTaken = irqOn_reg && bus.irqRequestLine;
    always_comb begin
        prdata = '0;
        case (paddr)
            REG_STATUS: prdata = {28'h0, bus.channelRequestLine, skip_reg,
                                  1'b0, (state_reg != ST_IDLE)};
            REG_RESULT: prdata = {16'h0, result_reg};
            REG_IRQ: prdata = {31'h0, irqTaken};
            REG_CMD: prdata = {24'h0, 2'h0, dev_reg};
            default: prdata = '0;
        endcase
    end
    assign pready = 1'b1;
    assign pslverr = psel && penable && !(paddr == REG_CMD || paddr == REG_STATUS
                     || paddr == REG_RESULT || paddr == REG_IRQ);
endmodule

// ---- design/piosi_pkg.sv ----
// shared constants and types for the programmed-io status and interrupt link
package piosi_pkg;
    // ------------------------------------------------------------
    // bus widths and codes
    // ------------------------------------------------------------
    localparam int DEV_CODE_W = 6;
    localparam int DATA_W = 16;
    localparam int SKIP_TEST_W = 2;
    localparam logic [5:0] ACK_DEV_CODE = 6'h3F;   // device code 77 octal
    localparam int ACK_CODE_LSB = 0;               // data bits 10-15 sit in the low six bits
    // ------------------------------------------------------------
    // skip test field encodings
    // ------------------------------------------------------------
    localparam logic [1:0] SKIP_IF_BUSY_ASSERTED = 2'h0;
    localparam logic [1:0] SKIP_IF_BUSY_CLEAR = 2'h1;
    localparam logic [1:0] SKIP_IF_DONE_ASSERTED = 2'h2;
    localparam logic [1:0] SKIP_IF_DONE_CLEAR = 2'h3;
    // ------------------------------------------------------------
    // flag control field encodings
    // ------------------------------------------------------------
    localparam logic [1:0] FLAG_NONE = 2'h0;
    localparam logic [1:0] FLAG_START = 2'h1;
    localparam logic [1:0] FLAG_CLEAR = 2'h2;
    localparam logic [1:0] FLAG_PULSE = 2'h3;
    // ------------------------------------------------------------
    // host sequencer timing, in clk cycles
    // ------------------------------------------------------------
    localparam logic [3:0] PHASE_CYCLES = 4'h4;
    // ------------------------------------------------------------
    // host register map (apb byte offsets)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_RESULT = 8'h08;
    localparam logic [7:0] REG_IRQ = 8'h0C;
    // command register fields
    localparam int CMD_DEV_LSB = 0;
    localparam int CMD_OP_LSB = 8;
    localparam int CMD_TEST_LSB = 12;
    localparam int CMD_FLAG_LSB = 16;
    localparam int CMD_IRQON_BIT = 20;
    // host operations
    typedef enum logic [1:0] {
        OP_SKIP = 2'h0,
        OP_FLAG = 2'h1,
        OP_ACK = 2'h2,
        OP_RESET = 2'h3
    } piosi_op_e;
endpackage

// ---- sim/piosi_link_sva.sv ----
// concurrent checks on the programmed-io bus between controller and device
`timescale 1ns/1ps
module piosi_link_sva
    import piosi_pkg::*;
#(
    parameter logic [5:0] DEV_CODE = 6'h11  // arbitrary device code
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // bus lines
    input wire logic [5:0] selCode,
    input wire logic selValid,
    input wire logic busyStatusLine,
    input wire logic doneStatusLine,
    input wire logic startPulse,
    input wire logic clearPulse,
    input wire logic generalPulse,
    input wire logic ioResetPulse,
    input wire logic requestEnableStrobe,
    input wire logic irqRequestLine,
    input wire logic irqAcknowledge,
    input wire logic irqPriorityInput,
    input wire logic irqPriorityOutput,
    input wire logic [15:0] ackData,
    input wire logic ackDataEn,
    input wire logic channelRequestLine
);
    // ------
    // helper ages
    // ------
    logic strobePrev_reg;
    logic [3:0] sinceFall_reg;
    logic [3:0] selAge_reg;
    logic selMatch;
    assign selMatch = selValid && (selCode == DEV_CODE);
    // ages saturate so a stale strobe or select never looks fresh again
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            strobePrev_reg <= 1'b1;
            sinceFall_reg <= 4'hF;
            selAge_reg <= 4'hF;
        end else begin
            strobePrev_reg <= requestEnableStrobe;
            sinceFall_reg <= (strobePrev_reg && !requestEnableStrobe) ? 4'h0 :
                (sinceFall_reg == 4'hF) ? 4'hF : sinceFall_reg + 4'h1;
            selAge_reg <= selMatch ? 4'h0 :
                (selAge_reg == 4'hF) ? 4'hF : selAge_reg + 4'h1;
        end
    end
    // ------
    // properties
    // ------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // the select synchroniser lets status trail the select by a few cycles
    a_status_needs_sel: assert property ((busyStatusLine || doneStatusLine) |-> selAge_reg <= 4'h7)
        else $error("status line driven while not selected");
    a_start_sets_busy: assert property ($rose(startPulse) && selMatch |-> ##[1:8] (busyStatusLine && !doneStatusLine))
        else $error("start pulse did not set busy and clear done");
    a_clear_both: assert property ($rose(clearPulse) && selMatch |-> ##[1:8] !(busyStatusLine || doneStatusLine))
        else $error("clear pulse left a flag set");
    a_pulse_in_sel: assert property ((startPulse || clearPulse || generalPulse) |-> selValid)
        else $error("flag pulse issued without a device selected");
    a_irq_on_strobe: assert property ($changed(irqRequestLine) |-> sinceFall_reg <= 4'h8)
        else $error("irq request changed away from a strobe fall");
    a_no_strobe_ack: assert property (irqAcknowledge |-> requestEnableStrobe)
        else $error("request strobe lowered during acknowledge");
    a_ack_code: assert property ($rose(irqAcknowledge) && irqPriorityInput && irqRequestLine |-> ##[0:8] (ackDataEn && ackData[5:0] == DEV_CODE))
        else $error("acknowledged requester did not return its code");
    a_ack_only_req: assert property (ackDataEn |-> irqRequestLine && irqPriorityInput)
        else $error("code returned without request and priority");
    a_chan_on_strobe: assert property ($changed(channelRequestLine) |-> sinceFall_reg <= 4'h8)
        else $error("channel request changed away from a strobe fall");
    a_prio_pass: assert property (irqPriorityOutput == (irqPriorityInput && !irqRequestLine))
        else $error("priority output wrong for input and request");
endmodule

// ---- sim/tb.sv ----
// self-checking bench joining the bus controller and the device controller
`timescale 1ns/1ps
module tb;
    import piosi_pkg::*;
    localparam logic [5:0] OWN_CODE = 6'h11;  // arbitrary device code
    // ------
    // signals
    // ------
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic chainHeadAsserted, operationFinishedSignal, irqDisable, channelWanted;
    logic busyFlag, doneFlag, startSeen, generalSeen;
    int nMismatch = 0;
    int checksDone = 0;
    int seed = 45026;
    int nStart = 0;
    int nGeneral = 0;
    logic [32:0] expQ[$];
    logic [31:0] maskQ[$];
    string nameQ[$];
    piosi_bus_if busLink();
    piosi_host piosi_host_i (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus(busLink), .chainHeadAsserted(chainHeadAsserted));
    piosi_device #(.DEV_CODE(OWN_CODE)) piosi_device_i (.clk(clk), .nrst(nrst), .bus(busLink),
        .operationFinishedSignal(operationFinishedSignal), .irqDisable(irqDisable),
        .channelWanted(channelWanted), .busyFlag(busyFlag), .doneFlag(doneFlag),
        .startSeen(startSeen), .generalSeen(generalSeen));
    piosi_link_sva #(.DEV_CODE(OWN_CODE)) piosi_link_sva_i (.clk(clk), .nrst(nrst),
        .selCode(busLink.selCode), .selValid(busLink.selValid),
        .busyStatusLine(busLink.busyStatusLine), .doneStatusLine(busLink.doneStatusLine),
        .startPulse(busLink.startPulse), .clearPulse(busLink.clearPulse),
        .generalPulse(busLink.generalPulse), .ioResetPulse(busLink.ioResetPulse),
        .requestEnableStrobe(busLink.requestEnableStrobe),
        .irqRequestLine(busLink.irqRequestLine), .irqAcknowledge(busLink.irqAcknowledge),
        .irqPriorityInput(busLink.irqPriorityInput),
        .irqPriorityOutput(busLink.irqPriorityOutput), .ackData(busLink.ackData),
        .ackDataEn(busLink.ackDataEn), .channelRequestLine(busLink.channelRequestLine));
    // ------
    // tasks
    // ------
    task check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        checksDone++;
        if (seen !== exp) begin
            nMismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task giveVerdict;
        $display("checks %0d mismatches %0d", checksDone, nMismatch);
        if (nMismatch == 0 && checksDone > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // request is held from setup until pready is seen at an access edge
    task apb(input logic wr, input logic [7:0] addr, input logic [31:0] data,
            output logic [31:0] rd);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            nMismatch++;
            giveVerdict;
        end
    endtask
    task readExpect(input logic [7:0] addr, input logic [32:0] exp, input logic [31:0] mask,
            input string what);
        logic [31:0] rd;
        expQ.push_back(exp);
        maskQ.push_back(mask);
        nameQ.push_back(what);
        apb(1'b0, addr, 32'h0, rd);
    endtask
    // one command with the cpu irq flag on, then poll until sequencing ends
    task cmd(input logic [5:0] dev, input logic [1:0] op, input logic [1:0] test,
            input logic [1:0] flag);
        logic [31:0] rd;
        int n;
        apb(1'b1, REG_CMD, {11'h0, 1'b1, 2'h0, flag, 2'h0, test, 2'h0, op, 2'h0, dev}, rd);
        n = 0;
        do begin
            apb(1'b0, REG_STATUS, 32'h0, rd);
            n++;
        end while (rd[0] !== 1'b0 && n < 40);
        if (n >= 40) begin
            nMismatch++;
            giveVerdict;
        end
        repeat (8) @(posedge clk);  // device synchroniser and irq flop settle
    endtask
    task skipAll(input logic [5:0] dev, input logic b, input logic d);
        logic skip;
        for (int t = 0; t < 4; t++) begin
            skip = (t == 0) ? b : (t == 1) ? !b : (t == 2) ? d : !d;
            cmd(dev, OP_SKIP, t[1:0], FLAG_NONE);
            readExpect(REG_STATUS, {30'h0, skip, 2'h0}, 32'h4, "skip result");
        end
    endtask
    task flags(input logic b, input logic d);
        check("busy flag", {32'h0, busyFlag}, {32'h0, b});
        check("done flag", {32'h0, doneFlag}, {32'h0, d});
    endtask
    task finishOp;
        @(posedge clk);
        operationFinishedSignal <= 1'b1;
        repeat (8) @(posedge clk);
        operationFinishedSignal <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    // ------
    // clock, monitor, watchdog
    // ------
    always #2 clk = ~clk;
    // the oldest note is taken off whenever a tracked read completes
    always @(posedge clk) begin
        if (expQ.size() > 0 && psel && penable && pready && !pwrite) begin
            check(nameQ.pop_front(), {pslverr, prdata & maskQ.pop_front()}, expQ.pop_front());
        end
        if (startSeen === 1'b1) nStart++;
        if (generalSeen === 1'b1) nGeneral++;
    end
    // 40 commands of about 30 cycles each, with ample margin
    initial begin
        repeat (30000) @(posedge clk);
        nMismatch++;
        giveVerdict;
    end
    // ------
    // stimulus
    // ------
    initial begin
        int rnd;
        logic [5:0] other;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {chainHeadAsserted, operationFinishedSignal, channelWanted} = '0;
        irqDisable = 1'b1;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        readExpect(REG_STATUS, 33'h0, 32'hD, "status after reset");
        readExpect(8'h10, {1'b1, 32'h0}, 32'h0, "unmapped read");
        flags(1'b0, 1'b0);
        $display("test reset done");
        cmd(OWN_CODE, OP_FLAG, 2'h0, FLAG_START);
        flags(1'b1, 1'b0);
        skipAll(OWN_CODE, 1'b1, 1'b0);
        finishOp;
        flags(1'b0, 1'b1);
        skipAll(OWN_CODE, 1'b0, 1'b1);
        $display("test start and completion done");
        for (int i = 0; i < 3; i++) begin
            rnd = $random(seed);
            other = rnd[5:0];
            if (other == OWN_CODE || other == ACK_DEV_CODE) other = 6'h12;
            cmd(other, OP_FLAG, 2'h0, FLAG_CLEAR);
            cmd(other, OP_FLAG, 2'h0, FLAG_START);
            cmd(other, OP_FLAG, 2'h0, FLAG_PULSE);
            flags(1'b0, 1'b1);
            skipAll(other, 1'b0, 1'b0);
        end
        $display("test foreign codes done");
        readExpect(REG_IRQ, 33'h0, 32'h1, "irq while disabled");
        irqDisable <= 1'b0;
        cmd(OWN_CODE, OP_SKIP, 2'h0, FLAG_NONE);
        readExpect(REG_IRQ, 33'h1, 32'h1, "irq raised");
        chainHeadAsserted <= 1'b1;
        cmd(ACK_DEV_CODE, OP_ACK, 2'h0, FLAG_NONE);
        readExpect(REG_RESULT, {27'h0, OWN_CODE}, 32'h3F, "acknowledge code");
        flags(1'b0, 1'b1);
        chainHeadAsserted <= 1'b0;
        cmd(OWN_CODE, OP_FLAG, 2'h0, FLAG_PULSE);
        check("general pulses", {1'b0, nGeneral}, 33'h1);
        $display("test interrupt done");
        channelWanted <= 1'b1;
        cmd(OWN_CODE, OP_SKIP, 2'h0, FLAG_NONE);
        readExpect(REG_STATUS, 33'h8, 32'h8, "channel request set");
        channelWanted <= 1'b0;
        cmd(OWN_CODE, OP_SKIP, 2'h0, FLAG_NONE);
        readExpect(REG_STATUS, 33'h0, 32'h8, "channel request clear");
        cmd(OWN_CODE, OP_FLAG, 2'h0, FLAG_CLEAR);
        flags(1'b0, 1'b0);
        readExpect(REG_IRQ, 33'h0, 32'h1, "irq dropped");
        $display("test channel and clear done");
        cmd(OWN_CODE, OP_FLAG, 2'h0, FLAG_START);
        cmd(OWN_CODE, OP_FLAG, 2'h0, FLAG_CLEAR);
        finishOp;
        flags(1'b0, 1'b0);
        cmd(OWN_CODE, OP_FLAG, 2'h0, FLAG_START);
        cmd(6'h12, OP_RESET, 2'h0, FLAG_NONE);
        flags(1'b0, 1'b0);
        check("start pulses", {1'b0, nStart}, 33'h3);
        $display("test reset and late completion done");
        giveVerdict;
    end
endmodule
